/* File: ouc_defs.vh */
// constants for the outdoor unit command handler: framing and reply
// codes, command codes, control bit positions, timing and register map
// assumes a 100 MHz core clock and a byte-level control link
`ifndef OUC_DEFS_VH
`define OUC_DEFS_VH

// framing and address bytes
`define OUC_FR_CMD      8'hE2
`define OUC_FR_CMD_B    8'hE8
`define OUC_FR_CMD_C    8'hEA
`define OUC_ADDR        8'h82
// reply codes
`define OUC_RP_ACCEPT   8'hE4
`define OUC_RP_NOFUNC   8'hE5
`define OUC_RP_PARITY   8'hE6
`define OUC_RP_FORMAT   8'hE7
`define OUC_RP_LOCKED   8'hED
`define OUC_RP_LOCKARG  8'hFF
`define OUC_RP_NONE     8'h00
// command codes
`define OUC_CMD_RESET   8'h0A
`define OUC_CMD_STATUS  8'h12
`define OUC_CMD_MANID   8'h5C
// continuation blocks fixed by a short supported command
`define OUC_CMD_BLKS    8'h00
// continuation block identifiers
`define OUC_BLK_WILD    8'hA0
// block geometry
`define OUC_BLK_LEN     4'h8
`define OUC_BLK_LAST    4'h7
`define OUC_PAYLOAD     4'h6
`define OUC_HEAD_SHORT  4'h3
`define OUC_HEAD_LONG   4'h4
// header byte positions
`define OUC_POS_FR      4'h0
`define OUC_POS_ADDR    4'h1
`define OUC_POS_CMD     4'h2
`define OUC_POS_LEN     4'h3
// crc generator x16+x12+x9+x5+x+1, seed zero
`define OUC_CRC_POLY    16'h1223
`define OUC_CRC_SEED    16'h0000
// faulty password count that locks the unit
`define OUC_PW_LOCK     3'h6
// timing
`define OUC_CLK_MHZ     100
`define OUC_TB_MIN_US   5000
`define OUC_TB_MAX_US   10000
// register map
`define OUC_REG_CTRL    4'h0
`define OUC_REG_STAT    4'h4
`define OUC_REG_ALRM    4'h8
// control register bits
`define OUC_CT_PA       0
`define OUC_CT_TXEN     1
`define OUC_CT_DL       2
`define OUC_CT_RUN      3
`define OUC_CT_RST      4'h0

`endif

/* File: ouc_crc16.v */
// byte-serial crc engine for continuation data, msb first
// assumes one byte per enabled cycle from logic on the same clock
`timescale 1ns/1ps
`include "ouc_defs.vh"

module ouc_crc16 (
   clk,
   rst,
   ce,
   clr,
   en,
   din,
   crc
);
   input  wire        clk;
   input  wire        rst;
   input  wire        ce;
   input  wire        clr;
   input  wire        en;
   input  wire [7:0]  din;
   output wire [15:0] crc;

   reg [15:0] crc_q;
   reg [15:0] crc_d;
   reg        fb;
   integer    i;

   // eight shift steps per byte; remainder is zero over data plus crc
   always @* begin
      crc_d = crc_q;
      fb = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
         fb = crc_d[15] ^ din[i];
         crc_d = {crc_d[14:0], 1'b0} ^ (fb ? `OUC_CRC_POLY : 16'h0000);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         crc_q <= `OUC_CRC_SEED;
      end else if (ce) begin
         if (clr) begin
            crc_q <= `OUC_CRC_SEED;
         end else if (en) begin
            crc_q <= crc_d;
         end
      end
   end

   assign crc = crc_q;
endmodule

/* File: ouc_handler.v */
// outdoor unit command handler: receives command blocks byte by byte,
// checks them and answers reset, status and identification requests
// assumes the link layer delivers bytes with a parity flag and marks
// the last byte of each block; all link ports share clk
// Functional notes
// (RL1) short fixed form: no length byte, ids are A0, crc may be dropped
// (RL2) replies over six data bytes go out as eight-byte blocks
// (RL3) reply blocks open with accept code, last byte is a checksum
// (RL4) gap between blocks longer than 5 ms, at most 10 ms
// (RL5) crc covers continuation data bytes only, not the header
// (RL6) crc polynomial x16+x12+x9+x5+x+1
// (RL7) indoor unit sends no management command during transmission
// (RL8) reset reloads synthesizer, clears status and alarms, keeps count
// (RL9) indoor unit sends no reset while amplifier is on
// (RL10) reject codes: unsupported, parity error, unknown format
// (RL11) reset while locked is refused with locked code
// (RL12) indoor unit waits ten seconds after a reset
// (RL13) status answers accept plus three bytes, even when locked
// (RL14) alarms latch until status read or reset
// (RL15) in download mode only download alarms and state bits count; the code applies no download masking
// (RL16) alarm byte: self test, unlock, supply, password count, download
// (RL17) state byte: amplifier, running, zero, download
// (RL18) third status byte reads zero
// (RL19) unit stays off-line until identification command
// (RL20) indoor unit waits ten seconds after power cycle
// (RL21) identification answers accept plus three organisation bytes
// (RL22) six bad passwords lock, amplifier and transmitter go off
// (RL23) blocks never exceed eight bytes
// (RL24) nonzero crc remainder means corrupted, not executed
`timescale 1ns/1ps
`include "ouc_defs.vh"

module ouc_handler #(
   parameter [7:0] OUI_0   = 8'h12, // arbitrary value
   parameter [7:0] OUI_1   = 8'h34, // arbitrary value
   parameter [7:0] OUI_2   = 8'h56, // arbitrary value
   parameter       RB      = 8,
   parameter       TW      = 20,
   parameter       GAP_CYC = `OUC_TB_MIN_US * `OUC_CLK_MHZ + 1,
   parameter       TMO_CYC = `OUC_TB_MAX_US * `OUC_CLK_MHZ
) (
   clk,
   rst,
   ce,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   rx_byte,
   rx_valid,
   rx_perr,
   rx_eob,
   tx_byte,
   tx_valid,
   tx_last,
   tx_ready,
   self_test_pin,
   synth_unlock_pin,
   supply_alm_pin,
   dl_crc_pin,
   dl_err_pin,
   pw_bad,
   pw_good,
   pa_on,
   tx_enable,
   synth_reload,
   online,
   locked
);
   input  wire       clk;
   input  wire       rst;
   input  wire       ce;
   input  wire [3:0] reg_addr;
   input  wire [7:0] reg_wdata;
   input  wire       reg_wr;
   input  wire       reg_rd;
   output reg  [7:0] reg_rdata;
   input  wire [7:0] rx_byte;
   input  wire       rx_valid;
   input  wire       rx_perr;
   input  wire       rx_eob;
   output reg  [7:0] tx_byte;
   output reg        tx_valid;
   output reg        tx_last;
   input  wire       tx_ready;
   input  wire       self_test_pin;
   input  wire       synth_unlock_pin;
   input  wire       supply_alm_pin;
   input  wire       dl_crc_pin;
   input  wire       dl_err_pin;
   input  wire       pw_bad;
   input  wire       pw_good;
   output reg        pa_on;
   output reg        tx_enable;
   output reg        synth_reload;
   output reg        online;
   output reg        locked;

   localparam [2:0] T_IDLE = 3'b001;
   localparam [2:0] T_SEND = 3'b010;
   localparam [2:0] T_GAP  = 3'b100;

   reg  [4:0]    pin_s1_q, pin_s2_q, alm_q;
   reg  [2:0]    pwcnt_q;
   reg  [3:0]    ctrl_q;
   reg           head_q, hl_q, perr_q, bad_q, eob_q, exec_q, exok_q;
   reg  [3:0]    bcnt_q;
   reg  [7:0]    fr_q, ad_q, cmd_q, len_q, conts_q, blk_q, ecode_q;
   reg  [TW-1:0] tmo_q, gap_q;
   reg  [7:0]    rbuf [0:RB-1];
   reg  [3:0]    rlen_q, pos_q, dptr_q;
   reg  [7:0]    csum_q;
   reg  [2:0]    ts_q;
   reg  [7:0]    nb;
   reg           nl;
   wire [15:0]   crc;
   wire          busy, take, ext, load, crc_en, crc_clr, hdr_ok;
   wire [7:0]    blk_nx, alm_byte, st_byte;

   // link bytes are ignored while an answer is pending or going out
   assign busy = exec_q | ~ts_q[0] | tx_valid;
   assign take = ce & rx_valid & ~busy;
   assign blk_nx = blk_q + 8'h01;
   assign crc_en = take & ~head_q & (bcnt_q != `OUC_POS_FR)
                 & (bcnt_q < `OUC_BLK_LAST); // RL5
   assign crc_clr = eob_q & head_q;
   assign hdr_ok = (fr_q == `OUC_FR_CMD) | (fr_q == `OUC_FR_CMD_B)
                 | (fr_q == `OUC_FR_CMD_C);

   // data crc over continuation payload only
   ouc_crc16 u_crc (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .clr (crc_clr),
      .en  (crc_en),
      .din (rx_byte),
      .crc (crc)
   ); // RL6

   // alarm pins come from outside the clock domain
   always @(posedge clk) begin
      if (rst) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
      end else if (ce) begin
         pin_s1_q <= {self_test_pin, synth_unlock_pin, supply_alm_pin,
                      dl_crc_pin, dl_err_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   // sticky alarms; a new alarm in the clearing cycle survives
   always @(posedge clk) begin
      if (rst) begin
         alm_q <= 5'h00;
      end else if (ce) begin
         if (exec_q & exok_q & ((cmd_q == `OUC_CMD_STATUS) |
             ((cmd_q == `OUC_CMD_RESET) & ~locked))) begin
            alm_q <= pin_s2_q; // RL14
         end else begin
            alm_q <= alm_q | pin_s2_q;
         end
      end
   end

   // faulty password count survives the reset command; rst clears it, as does pw_good while unlocked unless pw_bad counts in the same cycle
   always @(posedge clk) begin
      if (rst) begin
         pwcnt_q <= 3'h0;
         locked <= 1'b0;
      end else if (ce) begin
         if (pw_bad & (pwcnt_q != `OUC_PW_LOCK)) begin
            pwcnt_q <= pwcnt_q + 3'h1;
         end else if (pw_good & ~locked) begin
            pwcnt_q <= 3'h0;
         end
         if (pwcnt_q == `OUC_PW_LOCK) begin
            locked <= 1'b1; // RL22
         end
      end
   end

   // control register and the outputs it steers; lock forces amplifier and transmitter off
   always @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `OUC_CT_RST;
         pa_on <= 1'b0;
         tx_enable <= 1'b0;
         synth_reload <= 1'b0;
         online <= 1'b0;
      end else if (ce) begin
         synth_reload <= 1'b0;
         if (locked) begin
            ctrl_q[`OUC_CT_PA] <= 1'b0; // RL22
            ctrl_q[`OUC_CT_TXEN] <= 1'b0; // RL22
         end else if (reg_wr & (reg_addr == `OUC_REG_CTRL)) begin
            ctrl_q <= reg_wdata[3:0];
         end
         if (exec_q & exok_q & ~locked) begin
            if (cmd_q == `OUC_CMD_RESET) begin
               ctrl_q <= `OUC_CT_RST; // RL8
               synth_reload <= 1'b1; // RL8
               online <= 1'b0; // RL19
            end else if (cmd_q == `OUC_CMD_MANID) begin
               online <= 1'b1; // RL19
            end
         end
         pa_on <= ctrl_q[`OUC_CT_PA] & ~locked;
         tx_enable <= ctrl_q[`OUC_CT_TXEN] & ~locked;
      end
   end

   // register reads answer one cycle later; unmapped reads give zero
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `OUC_REG_CTRL: reg_rdata <= {4'h0, ctrl_q};
               `OUC_REG_STAT: reg_rdata <= {locked, online, 3'h0, pwcnt_q};
               `OUC_REG_ALRM: reg_rdata <= {3'h0, alm_q};
               default:       reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // block reception: header, then continuation blocks until count met
   always @(posedge clk) begin
      if (rst) begin
         head_q <= 1'b1;
         hl_q <= 1'b0;
         perr_q <= 1'b0;
         bad_q <= 1'b0;
         eob_q <= 1'b0;
         bcnt_q <= 4'h0;
         fr_q <= 8'h00;
         ad_q <= 8'h00;
         cmd_q <= 8'h00;
         len_q <= 8'h00;
         conts_q <= 8'h00;
         blk_q <= 8'h00;
         tmo_q <= {TW{1'b0}};
         exec_q <= 1'b0;
         exok_q <= 1'b0;
         ecode_q <= `OUC_RP_NONE;
      end else if (ce) begin
         exec_q <= 1'b0;
         eob_q <= take & rx_eob;
         if (take) begin
            perr_q <= perr_q | rx_perr;
            tmo_q <= {TW{1'b0}};
            if (bcnt_q == `OUC_BLK_LEN) begin
               bad_q <= 1'b1; // RL23
            end else begin
               bcnt_q <= bcnt_q + 4'h1;
            end
            if (head_q) begin
               case (bcnt_q)
                  `OUC_POS_FR:   fr_q <= rx_byte;
                  `OUC_POS_ADDR: ad_q <= rx_byte;
                  `OUC_POS_CMD:  cmd_q <= rx_byte;
                  `OUC_POS_LEN:  len_q <= rx_byte;
                  default:       len_q <= len_q;
               endcase
            end else if ((bcnt_q == `OUC_POS_FR) &
                         (rx_byte != `OUC_BLK_WILD) &
                         (~hl_q | (rx_byte != `OUC_BLK_WILD + blk_nx))) begin
               bad_q <= 1'b1; // RL1
            end
         end else if (~head_q & ~busy) begin
            tmo_q <= tmo_q + {{(TW-1){1'b0}}, 1'b1};
         end
         if (eob_q) begin
            bcnt_q <= 4'h0;
            if (head_q) begin
               hl_q <= (bcnt_q == `OUC_HEAD_LONG);
               conts_q <= (bcnt_q == `OUC_HEAD_LONG) ? len_q
                                                    : `OUC_CMD_BLKS; // RL1
               blk_q <= 8'h00;
               if (ad_q != `OUC_ADDR) begin
                  perr_q <= 1'b0; // other addressee: drop silently
                  bad_q <= 1'b0;
               end else if (~hdr_ok | (bcnt_q < `OUC_HEAD_SHORT) |
                            (bcnt_q > `OUC_HEAD_LONG) | bad_q | perr_q |
                            (((bcnt_q == `OUC_HEAD_LONG) ? len_q
                              : `OUC_CMD_BLKS) == 8'h00)) begin
                  exec_q <= 1'b1;
               end else begin
                  head_q <= 1'b0;
               end
            end else begin
               blk_q <= blk_nx;
               if ((blk_nx == conts_q) | bad_q | perr_q) begin
                  exec_q <= 1'b1;
               end
            end
         end else if (~head_q & (tmo_q >= TMO_CYC[TW-1:0])) begin
            bad_q <= 1'b1; // RL4
            exec_q <= bad_q & ~exec_q; // after bad_q, so E7
         end
         // parity or crc slips outrank format; only a clean code executes
         exok_q <= 1'b0;
         if (perr_q | (eob_q & ~head_q & hl_q & (crc != 16'h0000))) begin
            ecode_q <= `OUC_RP_PARITY; // RL24
         end else if (bad_q | ~hdr_ok | (head_q & eob_q &
                      ((bcnt_q < `OUC_HEAD_SHORT) |
                       (bcnt_q > `OUC_HEAD_LONG)))) begin
            ecode_q <= `OUC_RP_FORMAT; // RL10
         end else begin
            ecode_q <= `OUC_RP_NONE;
            exok_q <= 1'b1;
         end
         if (exec_q) begin
            head_q <= 1'b1;
            bcnt_q <= 4'h0;
            perr_q <= 1'b0;
            bad_q <= 1'b0;
         end
      end
   end

   // status bytes; built the same in download mode, no alarm or state bit is masked
   assign alm_byte = {alm_q[4:2], pwcnt_q, alm_q[1:0]}; // RL16
   assign st_byte = {4'h0, pa_on, ctrl_q[`OUC_CT_RUN], 1'b0,
                     ctrl_q[`OUC_CT_DL]}; // RL17

   // answer assembly into the reply buffer
   always @(posedge clk) begin
      if (rst) begin
         rlen_q <= 4'h0;
      end else if (ce & exec_q) begin
         rlen_q <= 4'h1;
         rbuf[0] <= `OUC_RP_ACCEPT;
         if (ecode_q != `OUC_RP_NONE) begin
            rbuf[0] <= ecode_q; // RL10
         end else if (cmd_q == `OUC_CMD_STATUS) begin
            rbuf[1] <= alm_byte; // RL13
            rbuf[2] <= st_byte; // RL15
            rbuf[3] <= 8'h00; // RL18
            rlen_q <= 4'h4;
         end else if (((cmd_q == `OUC_CMD_RESET) |
                       (cmd_q == `OUC_CMD_MANID)) & locked) begin
            rbuf[0] <= `OUC_RP_LOCKED; // RL11
            rbuf[1] <= `OUC_RP_LOCKARG;
            rlen_q <= 4'h2;
         end else if (cmd_q == `OUC_CMD_MANID) begin
            rbuf[1] <= OUI_0; // RL21
            rbuf[2] <= OUI_1;
            rbuf[3] <= OUI_2;
            rlen_q <= 4'h4;
         end else if (cmd_q != `OUC_CMD_RESET) begin
            rbuf[0] <= `OUC_RP_NOFUNC; // RL10
         end
      end
   end

   // more than six data bytes turns the answer into checksummed blocks
   assign ext = (rlen_q > `OUC_BLK_LAST); // RL2
   assign load = ts_q[1] & (~tx_valid | tx_ready);

   // next byte to present on the link
   always @* begin
      nb = rbuf[pos_q[2:0]];
      nl = (pos_q == rlen_q - 4'h1);
      if (ext) begin
         nl = (pos_q == `OUC_BLK_LAST);
         if (pos_q == `OUC_POS_FR) begin
            nb = `OUC_RP_ACCEPT; // RL3
         end else if (pos_q == `OUC_BLK_LAST) begin
            nb = csum_q; // RL3
         end else if (dptr_q < rlen_q) begin
            nb = rbuf[dptr_q[2:0]];
         end else begin
            nb = 8'h00;
         end
      end
   end

   // transmit sequencer with inter-block pause
   always @(posedge clk) begin
      if (rst) begin
         ts_q <= T_IDLE;
         tx_byte <= 8'h00;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         pos_q <= 4'h0;
         dptr_q <= 4'h1;
         csum_q <= 8'h00;
         gap_q <= {TW{1'b0}};
      end else if (ce) begin
         if (tx_valid & tx_ready & ~load) begin
            tx_valid <= 1'b0;
         end
         case (ts_q)
            T_IDLE: begin
               pos_q <= 4'h0;
               dptr_q <= 4'h1;
               csum_q <= 8'h00;
               if (exec_q) begin
                  ts_q <= T_SEND;
               end
            end
            T_SEND: begin
               if (load) begin
                  tx_byte <= nb;
                  tx_valid <= 1'b1;
                  tx_last <= nl;
                  pos_q <= pos_q + 4'h1;
                  if (ext & (pos_q != `OUC_POS_FR) &
                      (pos_q != `OUC_BLK_LAST)) begin
                     csum_q <= csum_q + nb;
                     dptr_q <= dptr_q + 4'h1;
                  end
                  if (nl) begin
                     pos_q <= 4'h0;
                     csum_q <= 8'h00;
                     gap_q <= {TW{1'b0}};
                     ts_q <= (ext & (dptr_q < rlen_q)) ? T_GAP : T_IDLE;
                  end
               end
            end
            T_GAP: begin
               if (~tx_valid) begin
                  gap_q <= gap_q + {{(TW-1){1'b0}}, 1'b1};
                  if (gap_q == GAP_CYC[TW-1:0]) begin
                     ts_q <= T_SEND; // RL4
                  end
               end
            end
            default: ts_q <= T_IDLE;
         endcase
      end
   end
endmodule

/* File: ouc_handler_properties.sv */
// concurrent checks on the command handler ports
// assumes a single clk domain with synchronous active-high rst
`timescale 1ns/1ps
module ouc_handler_properties (
   input wire       clk,
   input wire       rst,
   input wire       ce,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire [7:0] tx_byte,
   input wire       tx_valid,
   input wire       tx_last,
   input wire       tx_ready,
   input wire       pw_bad,
   input wire       pa_on,
   input wire       tx_enable,
   input wire       synth_reload,
   input wire       online,
   input wire       locked
);
   logic [3:0] nbyte_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // bytes accepted so far in the current reply block
   always @(posedge clk)
      if (rst)
         nbyte_q <= 4'h0;
      else if (ce && tx_valid && tx_ready)
         nbyte_q <= tx_last ? 4'h0 : nbyte_q + 4'h1;
   tx_hold_a: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte changed before acceptance");
   block_len_a: assert property (
      tx_valid |-> nbyte_q < 4'h8)
      else $error("reply block longer than eight bytes");
   first_code_a: assert property (
      tx_valid && nbyte_q == 4'h0 |-> tx_byte inside
         {8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hED})
      else $error("reply block opens with unknown code");
   reset_accept_a: assert property (
      synth_reload |-> !locked ##[0:4] (tx_valid && tx_byte == 8'hE4))
      else $error("synthesizer reload without accepted reset");
   lock_off_a: assert property (
      locked |=> !pa_on && !tx_enable)
      else $error("amplifier or transmitter on while locked");
   lock_keep_a: assert property (
      locked |=> locked)
      else $error("lock released without reset");
   lock_cause_a: assert property (
      $rose(locked) |-> $past(pw_bad, 2) || $past(pw_bad, 1))
      else $error("lock without faulty password");
   stat_read_a: assert property (
      reg_rd && reg_addr == 4'h4 |=>
         reg_rdata[7:6] == {$past(locked), $past(online)})
      else $error("status register lock or online bit wrong");
   rdata_idle_a: assert property (
      !reg_rd || reg_addr == 4'hC |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a mapped read");
   ctrl_pa_a: assert property (
      ce && reg_wr && reg_addr == 4'h0 && !locked |->
         ##2 pa_on == $past(reg_wdata[0], 2))
      else $error("amplifier does not follow control write");
endmodule

bind ouc_handler ouc_handler_properties chk_u (
   .clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .tx_byte, .tx_valid, .tx_last, .tx_ready, .pw_bad, .pa_on, .tx_enable,
   .synth_reload, .online, .locked);

/* File: ouc_idu_model.sv */
// indoor unit model: sends command blocks and collects reply bytes
// assumes it shares clk with the handler; slow mode stalls replies
`timescale 1ns/1ps
module ouc_idu_model (
   input  wire       clk,
   output reg  [7:0] rx_byte,
   output reg        rx_valid,
   output reg        rx_perr,
   output reg        rx_eob,
   input  wire [7:0] tx_byte,
   input  wire       tx_valid,
   input  wire       tx_last,
   output reg        tx_ready
);
   logic [7:0] rsp[$];
   logic       done = 1'b0;
   logic       slow = 1'b0;
   initial begin
      {rx_byte, rx_valid, rx_perr, rx_eob} = 11'h000;
      tx_ready = 1'b0;
   end
   // take reply bytes; slow mode only accepts every other cycle
   always @(posedge clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
         rsp.push_back(tx_byte);
         if (tx_last)
            done <= 1'b1;
      end
   end
   // one block of at most eight bytes; caller only sends when idle
   task automatic send(input logic [7:0] b[$], input int perr_at);
      for (int i = 0; i < b.size(); i++) begin
         @(posedge clk);
         rx_byte  <= b[i];
         rx_valid <= 1'b1;
         rx_perr  <= (i == perr_at);
         rx_eob   <= (i == b.size() - 1);
      end
      @(posedge clk);
      // released line shows the inverse so stale data never matches
      rx_byte <= ~b[b.size() - 1];
      {rx_valid, rx_perr, rx_eob} <= 3'b000;
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the command handler: register tasks, command
// sequences through the indoor unit model, expected replies by hand
`timescale 1ns/1ps
module testbench;
   typedef logic [7:0] ouc_bq_t[$];
   logic       clk = 1'b0;
   logic       rst, ce, reg_wr, reg_rd, pw_bad, pw_good;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [4:0] alm;
   wire  [7:0] reg_rdata, rx_byte, tx_byte;
   wire        rx_valid, rx_perr, rx_eob, tx_valid, tx_last, tx_ready;
   wire        pa_on, tx_enable, synth_reload, online, locked;
   int         n_mismatch = 0;
   int         tests_run = 0;
   ouc_bq_t    st_h = '{8'hE2, 8'h82, 8'h12};
   ouc_bq_t    id_h = '{8'hE2, 8'h82, 8'h5C};
   ouc_bq_t    rs_h = '{8'hE2, 8'h82, 8'h0A};
   ouc_bq_t    nil, cont;
   logic [15:0] c;

   initial forever #5 clk = ~clk;
   // short gap and timeout so multi-block traffic stays quick
   ouc_handler #(.GAP_CYC(20), .TMO_CYC(50)) dut_u (
      .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_perr(rx_perr), .rx_eob(rx_eob), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
      .self_test_pin(alm[4]), .synth_unlock_pin(alm[3]),
      .supply_alm_pin(alm[2]), .dl_crc_pin(alm[1]), .dl_err_pin(alm[0]),
      .pw_bad(pw_bad), .pw_good(pw_good), .pa_on(pa_on),
      .tx_enable(tx_enable), .synth_reload(synth_reload),
      .online(online), .locked(locked));
   ouc_idu_model idu_u (
      .clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_perr(rx_perr), .rx_eob(rx_eob), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 check("reg_rdata", exp, reg_rdata);
   endtask
   task automatic bad_pw(input int k);
      repeat (k) begin
         @(posedge clk);
         pw_bad <= 1'b1;
         @(posedge clk);
         pw_bad <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask
   // alarm pin pulse long enough to pass the two-flop synchroniser
   task automatic pin(input logic [4:0] v);
      @(posedge clk);
      alm <= v;
      repeat (4) @(posedge clk);
      alm <= 5'h00;
      repeat (4) @(posedge clk);
   endtask
   task automatic cmd(input string what, input ouc_bq_t h,
                      input ouc_bq_t cb, input int perr_at,
                      input ouc_bq_t exp);
      int n;
      idu_u.rsp.delete();
      idu_u.done = 1'b0;
      idu_u.send(h, perr_at);
      if (cb.size() > 0) begin
         repeat (10) @(posedge clk); // idle gap between blocks
         idu_u.send(cb, -1);
      end
      n = 0;
      while (!idu_u.done && n < 200) begin
         @(posedge clk);
         n++;
      end
      check({what, " length"}, 8'(exp.size()), 8'(idu_u.rsp.size()));
      foreach (exp[i])
         if (i < idu_u.rsp.size())
            check(what, exp[i], idu_u.rsp[i]);
      repeat (3) @(posedge clk);
   endtask
   function automatic ouc_bq_t st(input logic [7:0] aa, bb);
      return '{8'hE4, aa, bb, 8'h00};
   endfunction
   // msb-first crc, seed zero, over continuation data only
   function automatic logic [15:0] crc16(input ouc_bq_t d);
      logic [15:0] r;
      r = 16'h0000;
      foreach (d[i])
         for (int b = 7; b >= 0; b--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i][b]) ? 16'h1223 : 16'h0);
      return r;
   endfunction
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      {rst, ce, reg_wr, reg_rd, pw_bad, pw_good} = 6'b110000;
      {reg_addr, reg_wdata, alm} = 17'h00000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(4'h4, 8'h00);
      rd(4'hC, 8'h00);
      repeat (20) @(posedge clk); // boot wait
      cmd("manid", id_h, nil, -1, '{8'hE4, 8'h12, 8'h34, 8'h56});
      check("online", 1'b1, online);
      wr(4'h0, 8'h0D);
      check("pa_on", 1'b1, pa_on);
      pin(5'b00100);
      rd(4'h8, 8'h04);
      idu_u.slow = 1'b1;
      cmd("status", st_h, nil, -1, st(8'h20, 8'h0D));
      cmd("status", st_h, nil, -1, st(8'h00, 8'h0D));
      idu_u.slow = 1'b0;
      cmd("nofunc", '{8'hE2, 8'h82, 8'h33}, nil, -1, '{8'hE5});
      cmd("parity", st_h, nil, 1, '{8'hE6});
      cmd("format", '{8'hE0, 8'h82, 8'h12}, nil, -1, '{8'hE7});
      cmd("address", '{8'hE2, 8'h80, 8'h12}, nil, -1, nil);
      cont = '{8'hA0, 8'h11, 8'h22, 8'h33, 8'h44};
      c = crc16(cont[1:4]);
      cont = {cont, c[15:8], c[7:0], 8'h00};
      cmd("crc", {st_h, 8'h01}, cont, -1, st(8'h00, 8'h0D));
      cont[2] = cont[2] ^ 8'h01;
      cmd("crc bad", {st_h, 8'h01}, cont, -1, '{8'hE6});
      cmd("timeout", {st_h, 8'h01}, nil, -1, '{8'hE7});
      @(posedge clk);
      ce <= 1'b0;
      wr(4'h0, 8'h0C); // dropped while frozen
      ce <= 1'b1;
      check("pa_on frozen", 1'b1, pa_on);
      wr(4'h0, 8'h0C); // amplifier off before a reset
      bad_pw(2);
      pin(5'b10000);
      cmd("reset", rs_h, nil, -1, '{8'hE4});
      check("online", 1'b0, online);
      repeat (20) @(posedge clk); // shortened loader boot wait
      cmd("status", st_h, nil, -1, st(8'h08, 8'h00));
      wr(4'h0, 8'h03);
      check("tx_enable", 1'b1, tx_enable);
      bad_pw(4);
      check("locked", 1'b1, locked);
      check("pa_on", 1'b0, pa_on);
      check("tx_enable", 1'b0, tx_enable);
      cmd("reset", rs_h, nil, -1, '{8'hED, 8'hFF});
      cmd("status", st_h, nil, -1, st(8'h18, 8'h00));
      cmd("manid", id_h, nil, -1, '{8'hED, 8'hFF});
      rd(4'h4, 8'h86);
      give_verdict();
   end
   // watchdog, well past the six hundred or so cycles the sequence needs
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
endmodule
